// ---- tb_updown_pulse_counter_cco.sv ----
// Self-checking testbench of the up/down pulse counter
`timescale 1ns/1ps
module tb_updown_pulse_counter_cco;
    import upc_pkg::*;
    localparam int TIMEOUT_CYC = 20000;
    logic mclk = 1'b0;
    logic rst_b;
    upc_addr_t addr;
    upc_cnt_t wdata;
    logic wr_stb;
    logic rd_stb;
    upc_cnt_t rdata;
    logic in_a;
    logic in_b;
    logic [1:0] mode;
    logic cco;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;

    always #12.5 mclk = ~mclk;

    upc_top dut (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .RDATA(rdata), .IN_A(in_a), .IN_B(in_b), .MODE(mode), .COUNT_CONTROLLED_OUTPUT(cco), .IRQ(irq));
    upc_enc_model src (.clk(mclk), .a(in_a), .b(in_b));

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    always @(posedge mclk) begin
        cyc++;
        if (cyc == TIMEOUT_CYC) begin
            n_errors++;
            $display("FAIL at %0t: timeout", $time);
            wrap_up();
        end
    end

    task automatic chk16(input upc_cnt_t got, input upc_cnt_t exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk16
    // Waits past the edge so that registered outputs have settled
    task automatic chk1(input logic exp, input logic sel_irq);
        #1;
        comparisons++;
        if ((sel_irq ? irq : cco) !== exp) begin
            n_errors++;
            $display("FAIL at %0t: %s is %b", $time, sel_irq ? "irq" : "output", sel_irq ? irq : cco);
        end
    endtask : chk1
    task automatic wr(input upc_addr_t a, input upc_cnt_t d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe was taken
    task automatic rdc(input upc_addr_t a, input upc_cnt_t exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk16(rdata, exp);
    endtask : rdc

    task automatic t_reset;
        rdc(UPC_REG_CTRL, upc_cnt_t'(UPC_CTRL_RST_VAL));
        rdc(UPC_REG_COUNT, UPC_CNT_ZERO);
        rdc(UPC_REG_STATE, 16'h0000);
        wr(UPC_REG_COUNT, 16'h1234);
        rdc(UPC_REG_COUNT, UPC_CNT_ZERO);
        rdc(4'hf, 16'h0000);
        chk1(1'b0, 1'b0);
        chk1(1'b0, 1'b1);
    endtask : t_reset

    task automatic t_single_up;
        wr(UPC_REG_CTRL, 16'h0005);
        wr(UPC_REG_PRESET, 16'hfffd);
        rdc(UPC_REG_STATE, 16'h0001);
        wr(UPC_REG_CMD, 16'h0002);
        chk1(1'b1, 1'b0);
        src.pulse(1);
        rdc(UPC_REG_COUNT, 16'hfffe);
        chk1(1'b1, 1'b0);
        src.pulse(1);
        rdc(UPC_REG_COUNT, UPC_CNT_MAX);
        rdc(UPC_REG_STATE, 16'h0000);
        chk1(1'b0, 1'b0);
        rdc(UPC_REG_STATUS, 16'h0001);
        chk1(1'b0, 1'b1);
        src.pulse(1);
        rdc(UPC_REG_COUNT, UPC_CNT_ZERO);
        rdc(UPC_REG_STATUS, 16'h0003);
        wr(UPC_REG_MASK, 16'h0002);
        chk1(1'b1, 1'b1);
        rdc(UPC_REG_MASK, 16'h0002);
        wr(UPC_REG_STATUS, 16'h0002);
        chk1(1'b0, 1'b1);
        rdc(UPC_REG_STATUS, 16'h0001);
        wr(UPC_REG_STATUS, 16'h0007);
    endtask : t_single_up

    task automatic t_single_down;
        wr(UPC_REG_CTRL, 16'h0000);
        wr(UPC_REG_PRESET, 16'h0001);
        wr(UPC_REG_CMD, 16'h0002);
        wr(UPC_REG_CMD, 16'h0004);
        chk1(1'b0, 1'b0);
        wr(UPC_REG_CMD, 16'h0006);
        chk1(1'b1, 1'b0);
        src.pulse(1);
        rdc(UPC_REG_STATE, 16'h0002);
        wr(UPC_REG_CTRL, 16'h0004);
        wr(UPC_REG_PRESET, 16'h0002);
        src.pulse(2);
        rdc(UPC_REG_COUNT, UPC_CNT_ZERO);
        chk1(1'b0, 1'b0);
        src.pulse(1);
        rdc(UPC_REG_COUNT, UPC_CNT_MAX);
        rdc(UPC_REG_STATUS, 16'h0005);
        wr(UPC_REG_STATUS, 16'h0007);
        wr(UPC_REG_CMD, 16'h0001);
        rdc(UPC_REG_STATE, 16'h0001);
        wr(UPC_REG_MASK, 16'h0001);
        chk1(1'b0, 1'b1);
        wr(UPC_REG_PRESET, 16'h0001);
        src.pulse(1);
        chk1(1'b1, 1'b1);
        rdc(UPC_REG_STATUS, 16'h0001);
        wr(UPC_REG_STATUS, 16'h0001);
        chk1(1'b0, 1'b1);
        rdc(UPC_REG_MASK, 16'h0001);
        wr(UPC_REG_MASK, 16'h0000);
    endtask : t_single_down

    task automatic t_gate;
        wr(UPC_REG_CTRL, 16'h0003);
        wr(UPC_REG_PRESET, 16'h000a);
        src.pulse(3);
        rdc(UPC_REG_COUNT, 16'h000a);
        src.set_b(1'b1);
        src.pulse(3);
        rdc(UPC_REG_COUNT, 16'h000d);
        src.set_b(1'b0);
        wr(UPC_REG_CTRL, 16'h0001);
    endtask : t_gate

    // The mode pin is moved only while the inputs are idle
    task automatic t_quad(input logic [1:0] m, input int rate);
        @(posedge mclk);
        mode <= m;
        repeat (2) @(posedge mclk);
        wr(UPC_REG_PRESET, 16'h0064);
        src.quad(2, 1'b1);
        rdc(UPC_REG_COUNT, upc_cnt_t'(100 + 2 * rate));
        src.quad(1, 1'b0);
        rdc(UPC_REG_COUNT, upc_cnt_t'(100 + rate));
        rdc(UPC_REG_STATE, {12'h000, m, 2'b01});
    endtask : t_quad

    task automatic t_idle_mode;
        @(posedge mclk);
        mode <= 2'b11;
        repeat (2) @(posedge mclk);
        src.pulse(2);
        src.quad(1, 1'b1);
        rdc(UPC_REG_COUNT, 16'h0066);
    endtask : t_idle_mode

    initial begin
        rst_b <= 1'b0;
        addr <= '0;
        wdata <= '0;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        mode <= 2'b00;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_single_up();
        t_single_down();
        t_gate();
        t_quad(2'b01, 1);
        t_quad(2'b10, 2);
        t_idle_mode();
        wrap_up();
    end
endmodule : tb_updown_pulse_counter_cco

// ---- upc_enc_model.sv ----
// Pulse source and incremental shaft encoder model driving inputs A and B
`timescale 1ns/1ps
module upc_enc_model (
    input wire logic clk, // Clock
    output logic a, // Input A
    output logic b // Input B
);
    logic [1:0] seq_up [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [1:0] seq_dn [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    initial begin
        a <= 1'b0;
        b <= 1'b0;
    end
    // Each level is held two cycles so that no edge is lost to the sampler
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            a <= 1'b1;
            repeat (2) @(posedge clk);
            a <= 1'b0;
            @(posedge clk);
        end
    endtask : pulse
    task automatic set_b(input logic v);
        @(posedge clk);
        b <= v;
    endtask : set_b
    // A leads B when turning forward, B leads A when turning back
    task automatic quad(input int n, input logic up);
        repeat (n) begin
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                {a, b} <= up ? seq_up[i] : seq_dn[i];
                @(posedge clk);
            end
        end
    endtask : quad
endmodule : upc_enc_model

// ---- upc_irq.sv ----
// Sticky event status with mask and level interrupt
`timescale 1ns/1ps
module upc_irq #(
    parameter int EVT_W = 3
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [EVT_W-1:0] evt, // Event pulses
    input wire logic clr_we, // Write one to clear strobe
    input wire logic [EVT_W-1:0] clr_data, // Bits to clear
    input wire logic mask_we, // Mask write strobe
    input wire logic [EVT_W-1:0] mask_data, // New mask
    output logic [EVT_W-1:0] status, // Sticky status
    output logic [EVT_W-1:0] mask, // Mask register
    output logic irq // Level interrupt
);
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] mask_reg;
    // A new event beats a clear in the same cycle
    wire [EVT_W-1:0] status_next = (status_reg & ~(clr_we ? clr_data : '0)) | evt;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_reg <= '0;
            mask_reg <= '0;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_we ? mask_data : mask_reg;
        end
    end

    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = |(status_reg & mask_reg);

    a_irq_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        (|evt) |=> ((status_reg & $past(evt)) == $past(evt)))
        else $error("Event lost in status register");

endmodule : upc_irq

// ---- upc_pkg.sv ----
// Constants, register map and mode encoding for the up/down pulse counter
package upc_pkg;

    localparam int UPC_CNT_W = 16;
    localparam int UPC_ADDR_W = 4;
    localparam int UPC_EVT_W = 3;

    typedef logic [UPC_CNT_W-1:0] upc_cnt_t;
    typedef logic [UPC_ADDR_W-1:0] upc_addr_t;
    typedef logic [UPC_EVT_W-1:0] upc_evt_t;

    typedef enum logic [1:0] {
        SINGLE_PULSE_MODE = 2'b00,
        QUADRATURE_SINGLE_RATE = 2'b01,
        QUADRATURE_DOUBLE_RATE = 2'b10,
        MODE_IDLE = 2'b11
    } upc_mode_t;

    localparam upc_cnt_t UPC_CNT_MAX = 16'hffff;
    localparam upc_cnt_t UPC_CNT_ZERO = 16'h0000;
    localparam upc_cnt_t UPC_CNT_ONE = 16'h0001;

    // Register indices
    localparam upc_addr_t UPC_REG_CTRL = 4'h0;
    localparam upc_addr_t UPC_REG_PRESET = 4'h1;
    localparam upc_addr_t UPC_REG_COUNT = 4'h2;
    localparam upc_addr_t UPC_REG_STATUS = 4'h3;
    localparam upc_addr_t UPC_REG_MASK = 4'h4;
    localparam upc_addr_t UPC_REG_CMD = 4'h5;
    localparam upc_addr_t UPC_REG_STATE = 4'h6;

    // Control bits
    localparam int UPC_CTRL_DIR_UP = 0;
    localparam int UPC_CTRL_GATE_EN = 1;
    localparam int UPC_CTRL_RESET_EN = 2;
    localparam int UPC_CTRL_W = 3;
    localparam logic [UPC_CTRL_W-1:0] UPC_CTRL_RST_VAL = 3'h1;

    // Command bits
    localparam int UPC_CMD_SET_FLAG = 0;
    localparam int UPC_CMD_OUT_ON = 1;
    localparam int UPC_CMD_OUT_OFF = 2;

    // Event bits
    localparam int UPC_EVT_TERM = 0;
    localparam int UPC_EVT_WRAP_UP = 1;
    localparam int UPC_EVT_WRAP_DN = 2;

    // State register bits
    localparam int UPC_ST_FLAG = 0;
    localparam int UPC_ST_OUT = 1;
    localparam int UPC_ST_MODE_LO = 2;
    localparam int UPC_ST_MODE_HI = 3;

endpackage : upc_pkg

// ---- upc_step.sv ----
// Edge detection and direction decoding of inputs A and B
`timescale 1ns/1ps
module upc_step (
    input wire logic clk, // Clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic in_a, // Count input A
    input wire logic in_b, // Gate or second phase input B
    upc_step_if.decoder sif // Step request to the core
);
    import upc_pkg::*;

    logic a_prev_reg;
    wire a_rise = in_a & ~a_prev_reg;
    wire a_fall = ~in_a & a_prev_reg;
    wire single_step = a_rise & (~sif.gate_en | in_b);
    wire double_up = a_rise ? ~in_b : in_b;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= in_a;
        end
    end

    // Phase relation of A and B gives the direction in the encoder modes
    assign sif.step = (sif.mode == SINGLE_PULSE_MODE) ? single_step :
                      (sif.mode == QUADRATURE_SINGLE_RATE) ? a_rise :
                      (sif.mode == QUADRATURE_DOUBLE_RATE) ? (a_rise | a_fall) : 1'b0;
    assign sif.up = (sif.mode == SINGLE_PULSE_MODE) ? sif.dir_up :
                    (sif.mode == QUADRATURE_SINGLE_RATE) ? ~in_b : double_up;

    a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_b)
        (sif.mode == SINGLE_PULSE_MODE && sif.gate_en && !in_b) |-> !sif.step)
        else $error("Gated count passed while B inactive");
    a_x1_direction: assert property (@(posedge clk) disable iff (!rst_b)
        (sif.mode == QUADRATURE_SINGLE_RATE && sif.step) |-> (sif.up == !in_b && $rose(in_a)))
        else $error("Single rate step has wrong direction or edge");

endmodule : upc_step

// ---- upc_step_if.sv ----
// Step and direction signals between the input decoder and the counter core
`timescale 1ns/1ps
interface upc_step_if;
    import upc_pkg::*;
    upc_mode_t mode;
    logic gate_en;
    logic dir_up;
    logic step;
    logic up;
    modport decoder (input mode, input gate_en, input dir_up, output step, output up);
    modport core (output mode, output gate_en, output dir_up, input step, input up);
endinterface : upc_step_if

// ---- upc_top.sv ----
// Sixteen bit up/down pulse counter with terminal flag, controlled output and register port
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - One sixteen bit counter spans zero to 65,535; software extends range.
// - Gated mode counts A pulses only while B is active.
// - Encoder modes count up or down from the A to B phase relation.
// - Presetting the counter or a set command raises the terminal flag.
// - Counting up, the flag drops when the count reaches 65,535.
// - Counting down, the flag drops when the count reaches zero.
// - The terminal flag has no pin; it is read in bit 0 of the state register.
// - With clearing armed, the flag dropping drives the output low at once.
module upc_top (
    input wire logic MCLK, // 40 MHz clock
    input wire logic RST_B, // Synchronous reset, active low
    input wire upc_pkg::upc_addr_t ADDR, // Register index
    input wire upc_pkg::upc_cnt_t WDATA, // Write data
    input wire logic WR_STB, // Write strobe
    input wire logic RD_STB, // Read strobe
    output upc_pkg::upc_cnt_t RDATA, // Read data, one cycle after the strobe
    input wire logic IN_A, // Count input A
    input wire logic IN_B, // Gate or phase input B
    input wire logic [1:0] MODE, // Count mode jumper
    output logic COUNT_CONTROLLED_OUTPUT, // Counter controlled output
    output logic IRQ // Level interrupt
);
    import upc_pkg::*;

    upc_step_if sif ();

    upc_cnt_t count_reg;
    upc_cnt_t count_next;
    upc_cnt_t rdata_reg;
    upc_cnt_t rdata_next;
    upc_mode_t mode_reg;
    logic [UPC_CTRL_W-1:0] ctrl_reg;
    logic flag_reg;
    logic flag_next;
    logic out_reg;
    logic out_next;
    upc_evt_t evt;
    upc_evt_t status;
    upc_evt_t mask;

    function automatic logic hit(input upc_addr_t a, input upc_addr_t idx, input logic stb);
        hit = stb && (a == idx);
    endfunction : hit

    // Bus decode
    wire wr_ctrl = hit(ADDR, UPC_REG_CTRL, WR_STB);
    wire wr_preset = hit(ADDR, UPC_REG_PRESET, WR_STB);
    wire wr_status = hit(ADDR, UPC_REG_STATUS, WR_STB);
    wire wr_mask = hit(ADDR, UPC_REG_MASK, WR_STB);
    wire wr_cmd = hit(ADDR, UPC_REG_CMD, WR_STB);
    wire cmd_set_flag = wr_cmd & WDATA[UPC_CMD_SET_FLAG];
    wire cmd_out_on = wr_cmd & WDATA[UPC_CMD_OUT_ON];
    wire cmd_out_off = wr_cmd & WDATA[UPC_CMD_OUT_OFF];

    wire dir_up = ctrl_reg[UPC_CTRL_DIR_UP];
    wire gate_en = ctrl_reg[UPC_CTRL_GATE_EN];
    // Host must arm this before the last terminal count (65,535 counting up, zero counting down) it cares about
    wire reset_en = ctrl_reg[UPC_CTRL_RESET_EN];

    assign sif.mode = mode_reg;
    assign sif.gate_en = gate_en;
    assign sif.dir_up = dir_up;

    upc_step u_step (
        .clk(MCLK),
        .rst_b(RST_B),
        .in_a(IN_A),
        .in_b(IN_B),
        .sif(sif)
    );

    // A preset in the same cycle as a pulse wins; that pulse is dropped
    wire do_step = sif.step & ~wr_preset;
    wire step_up = do_step & sif.up;
    wire step_dn = do_step & ~sif.up;
    wire [UPC_CNT_W-1:0] count_inc = count_reg + UPC_CNT_ONE;
    wire [UPC_CNT_W-1:0] count_dec = count_reg - UPC_CNT_ONE;
    wire term_up = step_up & (count_inc == UPC_CNT_MAX);
    wire term_dn = step_dn & (count_dec == UPC_CNT_ZERO);
    wire term_hit = term_up | term_dn;
    wire wrap_up = step_up & (count_reg == UPC_CNT_MAX);
    wire wrap_dn = step_dn & (count_reg == UPC_CNT_ZERO);

    assign count_next = wr_preset ? WDATA :
                        step_up ? count_inc :
                        step_dn ? count_dec : count_reg;

    // Software set beats a terminal hit landing in the same cycle
    assign flag_next = (wr_preset | cmd_set_flag) ? 1'b1 :
                       term_hit ? 1'b0 : flag_reg;

    // Clearing beats a software set, so an armed output never stays high past the terminal
    assign out_next = (term_hit & reset_en) ? 1'b0 :
                      cmd_out_on ? 1'b1 :
                      cmd_out_off ? 1'b0 : out_reg;

    assign evt[UPC_EVT_TERM] = term_hit;
    assign evt[UPC_EVT_WRAP_UP] = wrap_up;
    assign evt[UPC_EVT_WRAP_DN] = wrap_dn;

    upc_irq #(
        .EVT_W(UPC_EVT_W)
    ) u_irq (
        .clk(MCLK),
        .rst_b(RST_B),
        .evt(evt),
        .clr_we(wr_status),
        .clr_data(WDATA[UPC_EVT_W-1:0]),
        .mask_we(wr_mask),
        .mask_data(WDATA[UPC_EVT_W-1:0]),
        .status(status),
        .mask(mask),
        .irq(IRQ)
    );

    // Read mux; unmapped indices and idle cycles read zero
    wire [UPC_CNT_W-1:0] state_word = {{(UPC_CNT_W-4){1'b0}}, mode_reg, out_reg, flag_reg};
    wire [UPC_CNT_W-1:0] ctrl_word = {{(UPC_CNT_W-UPC_CTRL_W){1'b0}}, ctrl_reg};
    wire [UPC_CNT_W-1:0] status_word = {{(UPC_CNT_W-UPC_EVT_W){1'b0}}, status};
    wire [UPC_CNT_W-1:0] mask_word = {{(UPC_CNT_W-UPC_EVT_W){1'b0}}, mask};
    wire [UPC_CNT_W-1:0] read_word = (ADDR == UPC_REG_CTRL) ? ctrl_word :
                                     (ADDR == UPC_REG_COUNT) ? count_reg :
                                     (ADDR == UPC_REG_STATUS) ? status_word :
                                     (ADDR == UPC_REG_MASK) ? mask_word :
                                     (ADDR == UPC_REG_STATE) ? state_word : UPC_CNT_ZERO;
    assign rdata_next = RD_STB ? read_word : UPC_CNT_ZERO;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            mode_reg <= MODE_IDLE;
        end else begin
            case (MODE)
                2'b00: mode_reg <= SINGLE_PULSE_MODE;
                2'b01: mode_reg <= QUADRATURE_SINGLE_RATE;
                2'b10: mode_reg <= QUADRATURE_DOUBLE_RATE;
                default: mode_reg <= MODE_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            count_reg <= UPC_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ctrl_reg <= UPC_CTRL_RST_VAL;
        end else begin
            ctrl_reg <= wr_ctrl ? WDATA[UPC_CTRL_W-1:0] : ctrl_reg;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            rdata_reg <= UPC_CNT_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // The terminal flag itself never reaches a pin
    assign COUNT_CONTROLLED_OUTPUT = out_reg;
    assign RDATA = rdata_reg;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence s_preset_write;
        wr_preset;
    endsequence

    sequence s_up_to_max;
        step_up && count_reg == 16'hfffe;
    endsequence

    sequence s_down_to_zero;
        step_dn && count_reg == 16'h0001;
    endsequence

    sequence s_armed_terminal;
        (s_up_to_max or s_down_to_zero) ##0 reset_en;
    endsequence

    sequence s_single_step;
        mode_reg == SINGLE_PULSE_MODE && sif.step;
    endsequence

    sequence s_flag_quiet;
        !wr_preset && !cmd_set_flag && !term_hit;
    endsequence

    sequence s_clear_write;
        wr_status && !(|evt);
    endsequence

    a_preset_loads: assert property (s_preset_write |=> (count_reg == $past(WDATA) && flag_reg))
        else $error("Preset did not load count and raise flag");
    a_cmd_sets_flag: assert property (cmd_set_flag |=> flag_reg)
        else $error("Set command did not raise flag");
    a_up_terminal: assert property (s_up_to_max ##0 !cmd_set_flag |=> (!flag_reg && count_reg == 16'hffff))
        else $error("Flag not cleared at top of range");
    a_down_terminal: assert property (s_down_to_zero ##0 !cmd_set_flag |=> (!flag_reg && count_reg == 16'h0000))
        else $error("Flag not cleared at zero");
    a_output_cleared: assert property (s_armed_terminal |=> !COUNT_CONTROLLED_OUTPUT)
        else $error("Controlled output not cleared with armed terminal");
    a_output_kept: assert property ((!reset_en && !wr_cmd) |=> $stable(COUNT_CONTROLLED_OUTPUT))
        else $error("Controlled output changed while clearing disarmed");
    a_count_hold: assert property ((!sif.step && !wr_preset) |=> $stable(count_reg))
        else $error("Count moved without a pulse or preset");
    a_count_step: assert property ((do_step && sif.up) |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Up step did not add one");
    a_gated_count: assert property ((mode_reg == SINGLE_PULSE_MODE && gate_en && !IN_B) |=>
        (count_reg == $past(count_reg) || $past(wr_preset)))
        else $error("Count moved while gate closed");
    a_read_window: assert property (RD_STB && ADDR == UPC_REG_COUNT |=> RDATA == $past(count_reg) ##1
        ($past(RD_STB) || RDATA == 16'h0000))
        else $error("Count read data wrong");
    a_read_idle: assert property (!RD_STB |=> RDATA == 16'h0000)
        else $error("Read data not zero outside read cycle");
    a_irq_follows: assert property ((term_hit && mask[UPC_EVT_TERM]) |=> IRQ [*2])
        else $error("Interrupt missing after masked-in terminal event");

    // Step decoding per mode, seen from the pins
    a_count_down: assert property ((do_step && !sif.up) |=> count_reg == $past(count_reg) - UPC_CNT_ONE)
        else $error("Down step did not subtract one");
    a_idle_still: assert property ((mode_reg == MODE_IDLE) |-> !sif.step)
        else $error("Step decoded with counting switched off");
    a_single_dir: assert property (s_single_step |-> sif.up == dir_up)
        else $error("Single pulse step ignores direction bit");
    a_gate_open: assert property ((mode_reg == SINGLE_PULSE_MODE && $rose(IN_A) && (!gate_en || IN_B)) |-> sif.step)
        else $error("Open gate dropped a pulse");
    a_x1_rate: assert property ((mode_reg == QUADRATURE_SINGLE_RATE && $fell(IN_A)) |-> !sif.step)
        else $error("Single rate counted a falling edge");
    a_double_edges: assert property ((mode_reg == QUADRATURE_DOUBLE_RATE && $changed(IN_A)) |-> sif.step)
        else $error("Double rate missed an edge of A");

    // The flag only drops on a terminal step
    a_flag_quiet: assert property (s_flag_quiet |=> $stable(flag_reg))
        else $error("Flag moved without a cause");
    a_flag_drop_cause: assert property ($fell(flag_reg) |-> $past(term_hit))
        else $error("Flag dropped away from the terminal");
    a_flag_set_beats: assert property ((term_hit && cmd_set_flag) |=> flag_reg)
        else $error("Set command lost against terminal");

    // The output moves only on a command or an armed terminal
    a_out_on_cmd: assert property ((cmd_out_on && !(term_hit && reset_en)) |=> COUNT_CONTROLLED_OUTPUT)
        else $error("Output on command ignored");
    a_out_off_cmd: assert property ((cmd_out_off && !cmd_out_on) |=> !COUNT_CONTROLLED_OUTPUT)
        else $error("Output off command ignored");
    a_out_rise_cause: assert property ($rose(COUNT_CONTROLLED_OUTPUT) |-> $past(cmd_out_on))
        else $error("Output rose without a command");
    a_out_fall_cause: assert property ($fell(COUNT_CONTROLLED_OUTPUT) |->
        $past(cmd_out_off || (term_hit && reset_en)))
        else $error("Output fell without a cause");

    // Events reach the sticky status
    a_term_status: assert property (term_hit |=> status[UPC_EVT_TERM])
        else $error("Terminal event not recorded");
    a_wrap_up_status: assert property (wrap_up |=> status[UPC_EVT_WRAP_UP])
        else $error("Upward wrap not recorded");
    a_wrap_dn_status: assert property (wrap_dn |=> status[UPC_EVT_WRAP_DN])
        else $error("Downward wrap not recorded");
    a_wrap_no_term: assert property ((wrap_up || wrap_dn) |-> !term_hit)
        else $error("Wrap step taken as terminal");
    a_status_clear: assert property (s_clear_write |=> (status & $past(WDATA[UPC_EVT_W-1:0])) == '0)
        else $error("Status bit survived its clear");

    // Register port writes and reads
    a_mask_write: assert property (wr_mask |=> mask == $past(WDATA[UPC_EVT_W-1:0]))
        else $error("Mask write lost");
    a_ctrl_write: assert property (wr_ctrl |=> ctrl_reg == $past(WDATA[UPC_CTRL_W-1:0]))
        else $error("Control write lost");
    a_read_ctrl: assert property ((RD_STB && ADDR == UPC_REG_CTRL) |=> RDATA[UPC_CTRL_W-1:0] == $past(ctrl_reg))
        else $error("Control read data wrong");
    a_read_state: assert property ((RD_STB && ADDR == UPC_REG_STATE) |=>
        RDATA[UPC_ST_OUT:UPC_ST_FLAG] == {$past(out_reg), $past(flag_reg)})
        else $error("State read lost flag or output");
    a_read_mask: assert property ((RD_STB && ADDR == UPC_REG_MASK) |=> RDATA[UPC_EVT_W-1:0] == $past(mask))
        else $error("Mask read data wrong");

endmodule : upc_top
